// >>> hw/fpu_pkg.sv
/*
  package for the flash protection unit: register addresses, field positions,
  reset values and access codes.
  assumes a 16-bit register port and a 24-bit flash address space.
*/
package fpu_pkg;
  // ************************************************************
  // widths and counts
  // ************************************************************
  localparam int unsigned FPU_DW      = 16;
  localparam int unsigned FPU_AW      = 24;
  localparam int unsigned FPU_NSECT   = 10;
  localparam int unsigned FPU_NPAIR   = 16;
  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [23:0] FPU_ADDR_DISABLE  = 24'h08dfbc;
  localparam logic [23:0] FPU_ADDR_REENABLE = 24'h08dfbe;
  localparam logic [23:0] FPU_ADDR_SECTOR   = 24'h08dfb4;
  localparam logic [23:0] FPU_ADDR_ACCDBG   = 24'h08dfb8;
  localparam logic [23:0] FPU_ADDR_TEMPUNP  = 24'h0e8000;
  // flash control register window (program/erase sequencer registers)
  localparam logic [23:0] FPU_CTRL_BASE     = 24'h080000;
  localparam logic [23:0] FPU_CTRL_LAST     = 24'h0800ff;
  // flash array data window
  localparam logic [23:0] FPU_ARRAY_BASE    = 24'h000000;
  localparam logic [23:0] FPU_ARRAY_LAST    = 24'h01ffff;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned FPU_ACCESS_PROTECT_FUSE_BIT = 0;
  localparam int unsigned FPU_DEBUG_PROTECT_FUSE_BIT = 1;
  localparam int unsigned FPU_TEMPORARY_UNPROTECT_BIT_BIT = 0;
  // ************************************************************
  // reset and trap values
  // ************************************************************
  localparam logic [15:0] FPU_FUSE_ERASED = 16'hffff;
  localparam logic [15:0] FPU_DUMMY_DATA  = 16'h0000;
  localparam logic [15:0] FPU_TRAP_NUM    = 16'h009b;
  // fuse load takes this many cycles after reset release
  localparam int unsigned FPU_LOAD_CYCLES = 4;
  // ************************************************************
  // load sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    FPU_ST_LOAD = 2'b01,
    FPU_ST_RUN  = 2'b10
  } fpu_state_t;
endpackage

// >>> hw/fpu_flash_protection_unit.sv
/*
  flash protection unit: fuse shadowing, access and write protection checks.
  assumes the cpu presents one access per cycle with a fetch-from-flash tag,
  and that fuse cells are read combinationally through nv_* inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module fpu_flash_protection_unit
  import fpu_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // non-volatile fuse cells
  input  wire logic [15:0]       nv_sector,
  input  wire logic [15:0]       nv_accdbg,
  input  wire logic [15:0]       nv_disable,
  input  wire logic [15:0]       nv_reenable,
  // cpu / event controller access
  input  wire logic              acc_valid,
  input  wire logic              acc_write,
  input  wire logic [23:0]       acc_addr,
  input  wire logic [15:0]       acc_wdata,
  input  wire logic              acc_from_flash,
  input  wire logic              acc_from_pec,
  // protection-setting operation from the sequencer
  input  wire logic              spr_start,
  input  wire logic [23:0]       spr_addr,
  input  wire logic [15:0]       spr_data,
  // program/erase requests by sector
  input  wire logic              pe_req,
  input  wire logic [3:0]        pe_sector,
  // results
  output logic                   acc_grant,
  output logic                   acc_trap,
  output logic [15:0]            acc_trap_num,
  output logic [15:0]            acc_rdata,
  output logic                   acc_rdata_valid,
  output logic                   pe_blocked,
  output logic                   spr_refused,
  output logic                   nv_prog,
  output logic [23:0]            nv_prog_addr,
  output logic [15:0]            nv_prog_data,
  output logic                   access_protected,
  output logic                   debug_enable,
  output logic                   loaded
);
  // ************************************************************
  // fuse load sequencing
  // ************************************************************
  fpu_state_t  state;
  logic [2:0]  load_cnt;
  logic [15:0] sh_sector;
  logic [15:0] sh_accdbg;
  logic [15:0] sh_disable;
  logic [15:0] sh_reenable;
  logic        temp_unprot;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= FPU_ST_LOAD;
      load_cnt <= '0;
    end else begin
      unique case (state)
        FPU_ST_LOAD: begin
          load_cnt <= load_cnt + 3'd1;
          if (load_cnt == 3'(FPU_LOAD_CYCLES - 1)) begin
            state <= FPU_ST_RUN;
          end
        end
        FPU_ST_RUN: begin
          state <= FPU_ST_RUN;
        end
      endcase
    end
  end
  assign loaded = (state == FPU_ST_RUN);

  // ************************************************************
  // protection-setting operation decode
  // ************************************************************
  logic spr_ok_dis;
  logic spr_ok_en;
  logic [15:0] dis_allow;
  logic [15:0] en_allow;
  logic spr_hit_sec;
  logic spr_hit_acc;
  logic spr_hit_dis;
  logic spr_hit_en;

  assign dis_allow[0] = ~sh_accdbg[FPU_ACCESS_PROTECT_FUSE_BIT] & ~sh_accdbg[FPU_DEBUG_PROTECT_FUSE_BIT];
  genvar g;
  generate
    for (g = 1; g < FPU_NPAIR; g++) begin : g_chain
      assign dis_allow[g] = ~sh_reenable[g-1];
    end
  endgenerate
  assign en_allow = ~sh_disable;
  assign spr_hit_sec = spr_addr == FPU_ADDR_SECTOR;
  assign spr_hit_acc = spr_addr == FPU_ADDR_ACCDBG;
  assign spr_hit_dis = spr_addr == FPU_ADDR_DISABLE;
  assign spr_hit_en  = spr_addr == FPU_ADDR_REENABLE;
  // cleared bits outside the allowed chain refuse the whole operation
  assign spr_ok_dis = ((~spr_data & sh_disable) & ~dis_allow) == 16'h0000;
  assign spr_ok_en  = ((~spr_data & sh_reenable) & ~en_allow) == 16'h0000;

  logic spr_go;
  // protected control registers reject the start
  assign spr_go = spr_start && loaded && !access_protected
                  && !(spr_hit_dis && !spr_ok_dis) && !(spr_hit_en && !spr_ok_en);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      spr_refused  <= 1'b0;
      nv_prog      <= 1'b0;
      nv_prog_addr <= '0;
      nv_prog_data <= FPU_FUSE_ERASED;
    end else begin
      spr_refused <= spr_start && !spr_go;
      // words reach the cells whole, ones included; the cells keep only the zeros
      // an all-ones sector word only lifts shadow bits, so pulsing the cells gains nothing
      nv_prog     <= spr_go && (spr_hit_acc || spr_hit_dis || spr_hit_en ||
                     (spr_hit_sec && spr_data != FPU_FUSE_ERASED));
      if (spr_go) begin
        nv_prog_addr <= spr_addr;
        nv_prog_data <= spr_data;
      end
    end
  end

  // ************************************************************
  // shadow registers
  // ************************************************************
  // forced protected values until load
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_sector   <= '0;
      sh_accdbg   <= '0;
      sh_disable  <= FPU_FUSE_ERASED;
      sh_reenable <= FPU_FUSE_ERASED;
    end else if (!loaded) begin
      if (load_cnt == 3'(FPU_LOAD_CYCLES - 1)) begin
        sh_sector   <= nv_sector;
        sh_accdbg   <= nv_accdbg;
        sh_disable  <= nv_disable;
        sh_reenable <= nv_reenable;
      end
    end else if (spr_go) begin
      if (spr_hit_acc) sh_accdbg   <= sh_accdbg & spr_data;
      if (spr_hit_dis) sh_disable  <= sh_disable & spr_data;
      if (spr_hit_en)  sh_reenable <= sh_reenable & spr_data;
      // sector shadow follows written value both ways
      if (spr_hit_sec) sh_sector   <= spr_data;
    end
  end

  // ************************************************************
  // temporary unprotect bit
  // ************************************************************
  logic hit_tau;
  assign hit_tau = acc_valid && acc_write && acc_addr == FPU_ADDR_TEMPUNP;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_unprot <= 1'b0;
    end else if (hit_tau) begin
      if (acc_wdata[FPU_TEMPORARY_UNPROTECT_BIT_BIT] && acc_from_flash) begin
        temp_unprot <= 1'b1;
      end else if (!acc_wdata[FPU_TEMPORARY_UNPROTECT_BIT_BIT]) begin
        temp_unprot <= 1'b0;
      end
    end
  end

  // ************************************************************
  // protection decisions
  // ************************************************************
  logic [15:0] pair_susp;
  logic        access_protect_fuse_suspended;
  // pair x suspends while disable x zero, enable x one
  assign pair_susp      = ~sh_disable & sh_reenable;
  assign access_protect_fuse_suspended = loaded && (pair_susp != 16'h0000);
  assign access_protected = !loaded ||
         (!sh_accdbg[FPU_ACCESS_PROTECT_FUSE_BIT] && !access_protect_fuse_suspended && !temp_unprot);
  // debug allowed only with erased fuse
  assign debug_enable = loaded && sh_accdbg[FPU_DEBUG_PROTECT_FUSE_BIT];

  logic in_array;
  logic in_ctrl;
  logic deny;
  assign in_array = acc_addr <= FPU_ARRAY_LAST;
  assign in_ctrl  = acc_addr >= FPU_CTRL_BASE && acc_addr <= FPU_CTRL_LAST;
  // in the array flash-fetched cpu code passes, others refused; control writes refused from any source
  assign deny = access_protected && (
                (in_array && (!acc_from_flash || acc_from_pec)) ||
                (in_ctrl && acc_write));
  assign acc_grant = acc_valid && !deny;

  // dummy data on refused reads; trap only on refused array reads not from the pec
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_trap        <= 1'b0;
      acc_trap_num    <= '0;
      acc_rdata       <= '0;
      acc_rdata_valid <= 1'b0;
    end else begin
      acc_trap        <= acc_valid && !acc_write && deny && in_array && !acc_from_pec;
      acc_trap_num    <= FPU_TRAP_NUM;
      acc_rdata_valid <= acc_valid && !acc_write && deny;
      acc_rdata       <= FPU_DUMMY_DATA;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pe_blocked <= 1'b0;
    end else begin
      pe_blocked <= pe_req && (!loaded || access_protected ||
                    (pe_sector < 4'(FPU_NSECT) && !sh_sector[pe_sector]));
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  // refusals are judged from the shadow bits, not from the allow vectors
  unprot_load_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !loaded |-> access_protected) else $error("unprotected before load");
  tau_src_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(temp_unprot) |-> $past(acc_from_flash)) else $error("temp set not from flash");
  tau_clr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (hit_tau && !acc_wdata[FPU_TEMPORARY_UNPROTECT_BIT_BIT]) |=> !temp_unprot)
    else $error("temp bit not cleared");
  trap_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (acc_valid && !acc_write && deny && in_array && !acc_from_pec) |=> acc_trap
    && acc_trap_num == 16'h009b) else $error("missing trap");
  otp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    loaded && $past(loaded) |-> (sh_disable & ~$past(sh_disable)) == 16'h0000)
    else $error("fuse bit rose");
  dis_chain_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (spr_start && spr_hit_dis && !spr_data[0] && sh_disable[0]
     && (sh_accdbg[FPU_ACCESS_PROTECT_FUSE_BIT] || sh_accdbg[FPU_DEBUG_PROTECT_FUSE_BIT])) |=> spr_refused)
    else $error("disable bit 0 out of order");
  en_chain_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (spr_start && spr_hit_en && (~spr_data & sh_reenable & sh_disable) != 16'h0000)
    |=> spr_refused) else $error("enable bit before its disable");
  spr_prot_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (spr_start && access_protected) |=> spr_refused && !nv_prog)
    else $error("setting op while protected");
  sect_one_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (spr_start && spr_hit_sec && spr_data == FPU_FUSE_ERASED) |=> !nv_prog)
    else $error("ones reached cells");
  pec_deny_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (access_protected && acc_valid && acc_from_pec && in_array) |-> !acc_grant)
    else $error("pec passed");
  ctrl_wr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (access_protected && acc_valid && acc_write && in_ctrl) |-> !acc_grant)
    else $error("control write passed");
  dbg_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (loaded && $past(loaded) && !$past(debug_enable)) |-> !debug_enable)
    else $error("debug came back");
  sect_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (pe_req && loaded && pe_sector < 4'd10 && !sh_sector[pe_sector]) |=> pe_blocked)
    else $error("sector not blocked");
  // ************************************************************
  // cover points
  // ************************************************************
  c_load_c: cover property (@(posedge core_clk) $rose(loaded));
  c_tau_c: cover property (@(posedge core_clk) $rose(temp_unprot));
  c_trap_c: cover property (@(posedge core_clk) acc_trap);
  c_susp_c: cover property (@(posedge core_clk) access_protect_fuse_suspended && !temp_unprot);
  c_refuse_c: cover property (@(posedge core_clk) spr_refused);
endmodule
`default_nettype wire

// >>> bench/fpu_fuse_model.sv
/*
  fuse cell model standing behind the protection unit's nv_* pins.
  assumes nv_prog pulses one cycle with its address and data already valid.
*/
`timescale 1ns/1ps
`default_nettype none
module fpu_fuse_model
  import fpu_pkg::*;
#(
  parameter logic [15:0] SECTOR_INIT = 16'hffff
)(
  input  wire logic        core_clk,
  input  wire logic        nv_prog,
  input  wire logic [23:0] nv_prog_addr,
  input  wire logic [15:0] nv_prog_data,
  output var  logic [15:0] nv_sector   = SECTOR_INIT,
  output var  logic [15:0] nv_accdbg   = FPU_FUSE_ERASED,
  output var  logic [15:0] nv_disable  = FPU_FUSE_ERASED,
  output var  logic [15:0] nv_reenable = FPU_FUSE_ERASED
);
  // cells only fall to zero
  // a one in the data never restores a cell, so ones leave the cells unchanged
  always @(posedge core_clk) begin
    if (nv_prog) begin
      case (nv_prog_addr)
        FPU_ADDR_SECTOR:   nv_sector   <= nv_sector & nv_prog_data;
        FPU_ADDR_ACCDBG:   nv_accdbg   <= nv_accdbg & nv_prog_data;
        FPU_ADDR_DISABLE:  nv_disable  <= nv_disable & nv_prog_data;
        FPU_ADDR_REENABLE: nv_reenable <= nv_reenable & nv_prog_data;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> bench/test_flash_protection_unit.sv
/*
  self-checking bench for the flash protection unit.
  assumes fpu_fuse_model supplies the fuse cells; inputs change 1 ns after the edge.
*/
`timescale 1ns/1ps
`default_nettype none
module test_flash_protection_unit
  import fpu_pkg::*;
();
  logic        core_clk = 1'b0, rst_b = 1'b0;
  logic        acc_valid = 1'b0, acc_write = 1'b0, acc_from_flash = 1'b0, acc_from_pec = 1'b0;
  logic [23:0] acc_addr = 24'h000000, spr_addr = 24'h000000;
  logic [15:0] acc_wdata = 16'h0000, spr_data = 16'h0000;
  logic        spr_start = 1'b0, pe_req = 1'b0;
  logic [3:0]  pe_sector = 4'h0;
  logic [15:0] nv_sector, nv_accdbg, nv_disable, nv_reenable, acc_trap_num, acc_rdata;
  logic [15:0] nv_prog_data;
  logic [23:0] nv_prog_addr;
  logic        acc_grant, acc_trap, acc_rdata_valid, pe_blocked, spr_refused, nv_prog;
  logic        access_protected, debug_enable, loaded, g_grant;
  int          failures = 0;
  int          n_tests = 0;
  always #5 core_clk = ~core_clk;
  fpu_fuse_model #(.SECTOR_INIT(16'hfffe)) u_fpu_fuse_model (.core_clk(core_clk),
    .nv_prog(nv_prog), .nv_prog_addr(nv_prog_addr), .nv_prog_data(nv_prog_data),
    .nv_sector(nv_sector), .nv_accdbg(nv_accdbg), .nv_disable(nv_disable),
    .nv_reenable(nv_reenable));
  fpu_flash_protection_unit u_fpu_flash_protection_unit (.core_clk(core_clk), .rst_b(rst_b),
    .nv_sector(nv_sector), .nv_accdbg(nv_accdbg), .nv_disable(nv_disable),
    .nv_reenable(nv_reenable), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_from_flash(acc_from_flash),
    .acc_from_pec(acc_from_pec), .spr_start(spr_start), .spr_addr(spr_addr),
    .spr_data(spr_data), .pe_req(pe_req), .pe_sector(pe_sector), .acc_grant(acc_grant),
    .acc_trap(acc_trap), .acc_trap_num(acc_trap_num), .acc_rdata(acc_rdata),
    .acc_rdata_valid(acc_rdata_valid), .pe_blocked(pe_blocked), .spr_refused(spr_refused),
    .nv_prog(nv_prog), .nv_prog_addr(nv_prog_addr), .nv_prog_data(nv_prog_data),
    .access_protected(access_protected), .debug_enable(debug_enable), .loaded(loaded));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk1(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic chkw(input logic [23:0] got, input logic [23:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic test_done();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  // every request starts one edge after the previous one was dropped
  task automatic acc(input logic wr, input logic [23:0] a, input logic [15:0] d,
                     input logic fl, input logic peripheral_event_controller);
    step();
    acc_valid = 1'b1;
    acc_write = wr;
    acc_addr = a;
    acc_wdata = d;
    acc_from_flash = fl;
    acc_from_pec = peripheral_event_controller;
    #1 g_grant = acc_grant;
    step();
    acc_valid = 1'b0;
  endtask
  task automatic spr(input logic [23:0] a, input logic [15:0] d);
    step();
    spr_start = 1'b1;
    spr_addr = a;
    spr_data = d;
    step();
    spr_start = 1'b0;
  endtask
  task automatic pe(input logic [3:0] s);
    step();
    pe_req = 1'b1;
    pe_sector = s;
    step();
    pe_req = 1'b0;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic do_reset();
    step();
    rst_b = 1'b0;
    repeat (5) step();
    chk1(access_protected, 1'b1, "not protected in reset");
    chk1(loaded, 1'b0, "loaded in reset");
    rst_b = 1'b1;
    repeat (3) step();
    chk1(loaded, 1'b0, "loaded early");
    step();
    chk1(loaded, 1'b1, "not loaded");
  endtask
  task automatic t_sector();
    pe(4'h0);
    chk1(pe_blocked, 1'b1, "sector 0 open");
    pe(4'h1);
    chk1(pe_blocked, 1'b0, "sector 1 blocked");
    spr(FPU_ADDR_SECTOR, 16'hffff);
    chk1(nv_prog, 1'b0, "ones reached cells");
    chk1(nv_sector[0], 1'b0, "cell lost its zero");
    pe(4'h0);
    chk1(pe_blocked, 1'b0, "unprotect lost");
    spr(FPU_ADDR_SECTOR, 16'hfffe);
    pe(4'h0);
    chk1(pe_blocked, 1'b1, "sector not restored");
  endtask
  task automatic t_access_protect_fuse();
    chk1(debug_enable, 1'b1, "debug off");
    acc(1'b0, FPU_ARRAY_BASE, 16'h0000, 1'b0, 1'b0);
    chk1(g_grant, 1'b1, "open read denied");
    spr(FPU_ADDR_DISABLE, 16'hfffe);
    chk1(spr_refused, 1'b1, "disable 0 accepted");
    // set temp bit, program fuse, clear
    acc(1'b1, FPU_ADDR_TEMPUNP, 16'h0001, 1'b1, 1'b0);
    spr(FPU_ADDR_ACCDBG, 16'hfffe);
    chk1(nv_prog, 1'b1, "no fuse program");
    chkw(nv_prog_addr, FPU_ADDR_ACCDBG, "prog addr");
    chkw({8'h00, nv_prog_data}, 24'h00fffe, "prog data");
    acc(1'b1, FPU_ADDR_TEMPUNP, 16'h0000, 1'b1, 1'b0);
    do_reset();
    chk1(access_protected, 1'b1, "fuse not reloaded");
  endtask
  task automatic t_prot();
    acc(1'b0, FPU_ARRAY_BASE + 24'h000010, 16'h0000, 1'b0, 1'b0);
    chk1(g_grant, 1'b1 ^ 1'b1, "ram read granted");
    chk1(acc_trap, 1'b1, "no trap");
    chkw({8'h00, acc_trap_num}, {8'h00, FPU_TRAP_NUM}, "trap number");
    chk1(acc_rdata_valid, 1'b1, "no dummy");
    chkw({8'h00, acc_rdata}, {8'h00, FPU_DUMMY_DATA}, "dummy data");
    acc(1'b1, FPU_ARRAY_LAST, 16'h1234, 1'b0, 1'b0);
    chk1(g_grant, 1'b0, "ram write granted");
    acc(1'b0, FPU_ARRAY_BASE, 16'h0000, 1'b1, 1'b0);
    chk1(g_grant, 1'b1, "flash read denied");
    acc(1'b0, FPU_ARRAY_BASE, 16'h0000, 1'b1, 1'b1);
    chk1(g_grant, 1'b0, "event read granted");
    acc(1'b1, FPU_CTRL_BASE, 16'h0100, 1'b0, 1'b0);
    chk1(g_grant, 1'b0, "ctrl write granted");
    spr(FPU_ADDR_SECTOR, 16'hffff);
    chk1(spr_refused, 1'b1, "spr accepted");
  endtask
  task automatic t_temp();
    acc(1'b1, FPU_ADDR_TEMPUNP, 16'h0001, 1'b0, 1'b0);
    chk1(access_protected, 1'b1, "ram set temp bit");
    acc(1'b1, FPU_ADDR_TEMPUNP, 16'h0001, 1'b1, 1'b0);
    chk1(access_protected, 1'b0, "temp bit ignored");
    acc(1'b0, FPU_ARRAY_BASE, 16'h0000, 1'b0, 1'b1);
    chk1(g_grant, 1'b1, "unprotected event denied");
    acc(1'b1, FPU_ADDR_TEMPUNP, 16'h0000, 1'b0, 1'b0);
    chk1(access_protected, 1'b1, "not restored");
  endtask
  task automatic t_pair();
    acc(1'b1, FPU_ADDR_TEMPUNP, 16'h0001, 1'b1, 1'b0);
    spr(FPU_ADDR_ACCDBG, 16'hfffc);
    chk1(debug_enable, 1'b0, "debug still on");
    spr(FPU_ADDR_DISABLE, 16'hfffe);
    chk1(spr_refused, 1'b0, "disable 0 refused");
    acc(1'b1, FPU_ADDR_TEMPUNP, 16'h0000, 1'b1, 1'b0);
    chk1(access_protected, 1'b0, "pair 0 not suspending");
    spr(FPU_ADDR_DISABLE, 16'hfffc);
    chk1(spr_refused, 1'b1, "disable 1 before enable 0");
    spr(FPU_ADDR_REENABLE, 16'hfffd);
    chk1(spr_refused, 1'b1, "enable 1 before disable 1");
    spr(FPU_ADDR_REENABLE, 16'hfffe);
    chk1(spr_refused, 1'b0, "enable 0 refused");
    chk1(access_protected, 1'b1, "fuse not back in force");
  endtask
  initial begin
    do_reset();
    t_sector();
    t_access_protect_fuse();
    t_prot();
    t_temp();
    t_pair();
    test_done();
  end
  // the sequence needs about 76 cycles, so 20 us is a generous cut-off
  initial begin
    #20000;
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
